/* File: common/tcmv_pkg.sv */
// constants, field layout and mode type for one timer channel block
// assumes a 32-bit axi4-lite bus with byte registers in the low lane
package tcmv_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_VAL_HI = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_VAL_LO = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CFG    = 8'h0C;

  // channel_control field positions
  localparam int unsigned CTRL_ELS_LO = 2;
  localparam int unsigned CTRL_ELS_HI = 3;
  localparam int unsigned CTRL_MS_LO  = 4;
  localparam int unsigned CTRL_MS_HI  = 5;

  // timer_config field positions
  localparam int unsigned CFG_CENTER_ALIGN_SELECT   = 0;
  localparam int unsigned CFG_CLKS_LO = 1;
  localparam int unsigned CFG_CLKS_HI = 2;

  // edge/level encodings
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;

  // clock select: 00 none, 01 bus, 10 fixed, 11 external
  localparam logic [1:0] CLKS_NONE = 2'h0;

  localparam logic [3:0]  CTRL_RESET  = 4'h0;
  localparam logic [2:0]  CFG_RESET   = 3'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] MOD_FREE    = 16'h0000;
  localparam logic [15:0] FREE_TOP    = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_ALIGNED_PWM,
    MODE_CENTER_ALIGNED_PWM
  } tcmv_mode_t;

endpackage : tcmv_pkg

/* File: dv/tcmv_channel_tb.sv */
// bench for one timer channel: bus access, mode decode, pin and value
// assumes the counter model drives the channel's counter inputs
`timescale 1ns/1ps
`default_nettype none

module tcmv_channel_tb;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, background_debug_mode = 1'h0;
  logic        pin_in = 1'h0, run = 1'h0, center = 1'h0;
  logic [15:0] modulo_value = 16'h0010;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, count_advance, count_up, pin_out, pin_oe;
  logic        pin_timer_owned, capture_event, compare_match;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [15:0] counter_value, ev, r;
  logic [31:0] lfsr_q = 32'h99FC444E;
  logic [7:0]  b;
  int          miscompares = 0, compares = 0, cycles = 0, ncap = 0;

  tcmv_channel dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .counter_value, .modulo_value,
    .count_advance, .count_up, .background_debug_mode, .pin_in, .pin_out,
    .pin_oe, .pin_timer_owned, .capture_event, .compare_match
  );
  tcmv_counter_model cnt_model (
    .aclk, .aresetn, .run, .center, .modulo_value, .counter_value,
    .count_advance, .count_up
  );

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (capture_event === 1'h1) ncap <= ncap + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // pin driven only when timer-owned and not capturing
  function automatic logic exp_oe(input logic [4:0] m);
    return m[1:0] != 2'h0 && (m[4] || m[3:2] != 2'h0);
  endfunction : exp_oe

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    b = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask : rd

  // k selects the low byte, else the high byte
  task automatic wv(input logic k, input logic [7:0] d);
    wr(k ? tcmv_pkg::ADDR_VAL_LO : tcmv_pkg::ADDR_VAL_HI, d);
  endtask : wv

  task automatic rv(input logic k);
    rd(k ? tcmv_pkg::ADDR_VAL_LO : tcmv_pkg::ADDR_VAL_HI);
  endtask : rv

  task automatic ctl(input logic [1:0] ms, input logic [1:0] els);
    wr(tcmv_pkg::ADDR_CTRL, {2'h0, ms, els, 2'h0});
  endtask : ctl

  task automatic cfg(input logic [7:0] d);
    wr(tcmv_pkg::ADDR_CFG, d);
  endtask : cfg

  task automatic chk16(input logic [15:0] exp);
    logic [7:0] h;
    rv(1'h0);
    h = b;
    rv(1'h1);
    chk_val({h, b}, exp);
  endtask : chk16

  task automatic step(input int n);
    run <= 1'h1;
    repeat (n) @(posedge aclk);
    run <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask : step

  // counter is frozen while the pin edge lands, so the capture is known
  task automatic cap();
    lfsr_q = lfsr(lfsr_q);
    step(int'(lfsr_q[2:0]) + 1);
    pin_in <= ~pin_in;
    repeat (3) @(posedge aclk);
    ev = counter_value;
  endtask : cap

  task automatic wait_cnt(input logic [15:0] v);
    do @(posedge aclk); while (counter_value !== v || count_up !== 1'h1);
  endtask : wait_cnt

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    ev = tcmv_pkg::VALUE_RESET;
    rd(tcmv_pkg::ADDR_CTRL);
    chk_val({8'h00, b}, 16'h0000);
    chk16(ev);
    rd(8'h10);
    chk_val({14'h0000, resp}, {14'h0000, tcmv_pkg::RESP_SLVERR});
    wr(8'h10, 8'h00);
    chk_val({14'h0000, resp}, {14'h0000, tcmv_pkg::RESP_SLVERR});
    for (int i = 0; i < 32; i++) begin
      cfg({7'h00, i[4]});
      ctl(i[3:2], i[1:0]);
      chk_bit(pin_timer_owned, i[1:0] != 2'h0);
      chk_bit(pin_oe, exp_oe(5'(i)));
    end
    cfg(8'h02);
    repeat (2) @(posedge aclk);
    for (int e = 1; e < 4; e++) begin
      ctl(2'h0, 2'(e));
      for (int k = 0; k < 2; k++) begin
        r = ev;
        cap();
        if (!e[k]) ev = r;
        chk16(ev);
      end
    end
    wv(1'h0, 8'hA5);
    wv(1'h1, 8'h5A);
    chk16(ev);
    r = ev;
    rv(1'h0);
    cap();
    rv(1'h1);
    chk_val({8'h00, b}, {8'h00, r[7:0]});
    rv(1'h0);
    cap();
    ctl(2'h0, 2'h3);
    rv(1'h1);
    chk_val({8'h00, b}, {8'h00, ev[7:0]});
    r = ev;
    rv(1'h0);
    rv(1'h0);
    background_debug_mode <= 1'h1;
    cap();
    rv(1'h1);
    chk_val({8'h00, b}, {8'h00, ev[7:0]});
    background_debug_mode <= 1'h0;
    rv(1'h1);
    chk_val({8'h00, b}, {8'h00, r[7:0]});
    chk_val(16'(ncap), 16'h0007);
    cfg(8'h00);
    ctl(2'h1, 2'h1);
    for (int k = 0; k < 2; k++) begin
      lfsr_q = lfsr(lfsr_q);
      r = lfsr_q[15:0];
      wv(k[0], k[0] ? r[7:0] : r[15:8]);
      chk16(ev);
      wv(!k[0], k[0] ? r[15:8] : r[7:0]);
      ev = r;
      chk16(ev);
    end
    lfsr_q = lfsr(lfsr_q);
    r = lfsr_q[15:0];
    wv(1'h0, r[15:8]);
    ctl(2'h1, 2'h1);
    wv(1'h1, r[7:0]);
    chk16(ev);
    background_debug_mode <= 1'h1;
    wv(1'h1, 8'h11);
    wv(1'h0, 8'h22);
    chk16(16'h2211);
    background_debug_mode <= 1'h0;
    lfsr_q = lfsr(lfsr_q);
    wv(1'h0, lfsr_q[7:0]);
    ev = {lfsr_q[7:0], r[7:0]};
    chk16(ev);
    cfg(8'h02);
    wv(1'h0, 8'h00);
    wv(1'h1, 8'h05);
    chk16(ev);
    step(1);
    ev = 16'h0005;
    chk16(ev);
    run <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      wait_cnt(16'h000A);
      if (k < 3) ctl(2'h1, 2'(3 - k));
      wait_cnt(16'h0007);
      chk_bit(pin_out, !k[0]);
    end
    ctl(2'h2, 2'h2);
    wait_cnt(16'h0003);
    run <= 1'h0;
    wv(1'h0, 8'h00);
    wv(1'h1, 8'h08);
    chk16(ev);
    run <= 1'h1;
    wait_cnt(16'h0000);
    ev = 16'h0008;
    chk16(ev);
    for (int k = 0; k < 4; k++) begin
      center <= k[1];
      cfg({5'h00, 2'h1, k[1]});
      ctl(2'h2, k[0] ? 2'h1 : 2'h2);
      repeat (2) wait_cnt(16'h000A);
      chk_bit(pin_out, k[0]);
      wait_cnt(16'h0002);
      chk_bit(pin_out, !k[0]);
    end
    summarize();
  end
endmodule : tcmv_channel_tb

`default_nettype wire

/* File: dv/tcmv_counter_model.sv */
// far-side model of the main counter, one step a cycle while run is high
// assumes the bench keeps center in step with the block's center bit
`timescale 1ns/1ps
`default_nettype none

module tcmv_counter_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // counting control
  input  wire logic        run,
  input  wire logic        center,
  input  wire logic [15:0] modulo_value,
  // counter state
  output logic [15:0]      counter_value,
  output logic             count_advance,
  output logic             count_up
);
  logic [15:0] top;
  logic        turn;

  // zero modulo means free running over the full range
  assign top = (modulo_value == 16'h0000) ? 16'hFFFF
                                          : modulo_value;
  assign turn = count_up ? (counter_value == top)
                         : (counter_value == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= 16'h0000;
      count_advance <= 1'h0;
      count_up      <= 1'h1;
    end else begin
      // a stopped counter gives no advance strobe
      count_advance <= run;
      if (run && !center) begin
        counter_value <= turn ? 16'h0000 : counter_value + 16'h0001;
      end else if (run) begin
        if (turn) count_up <= !count_up;
        counter_value <= (count_up != turn) ? counter_value + 16'h0001
                                            : counter_value - 16'h0001;
      end
      if (!center) count_up <= 1'h1;
    end
  end
endmodule : tcmv_counter_model

`default_nettype wire

/* File: hdl/tcmv_channel.sv */
// one timer channel: mode decode, pin action, coherent 16-bit value access
// assumes the main counter, modulo and debug state come from outside,
// and that count_advance pulses in the cycle counter_value takes a new value
//
// Overview of operation
// - center-align off and mode hi bit set gives edge-aligned pwm.
// - center-align off, mode hi clear: mode lo picks capture or compare.
// - edge/level 00 releases the pin to general-purpose io.
// - capture edge: 01 rising, 10 falling, 11 both.
// - compare match: 01 toggles, 10 drives low, 11 drives high.
// - edge pwm: 10 high-true clear on match, x1 low-true set on match.
// - center pwm: 10 clears on up match, x1 sets on up match.
// - value register holds capture or compare value, reset to zero.
// - capture mode read of one byte latches both until other byte read.
// - any control write releases the read latch, debug or not.
// - value writes are ignored in capture mode.
// - in debug the read latch keeps its state except control writes.
// - debug reads return live value, not the read buffer.
// - compare/pwm writes buffer both bytes, then load as one word.
// - with no clock selected, load on the second byte write.
// - clock selected in compare mode: load on next counter change.
// - clock selected in pwm: load as counter steps to modulo.
// - a control write resets the write byte sequence.
// - debug writes go straight to the value, buffer state frozen.
// - debug writes leave a half-done buffered sequence intact.
// - the block's center-align bit forces this channel to center pwm.
// - clock select 00 means no clock and a stopped counter.
`timescale 1ns/1ps
`default_nettype none

module tcmv_channel (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // main counter context
  input  wire logic [15:0] counter_value,
  input  wire logic [15:0] modulo_value,
  input  wire logic        count_advance,
  input  wire logic        count_up,
  input  wire logic        background_debug_mode,
  // channel pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             pin_timer_owned,
  // channel events
  output logic             capture_event,
  output logic             compare_match
);

  logic [3:0]          ctrl_q;
  logic [2:0]          cfg_q;
  logic [15:0]         value_q;
  logic [7:0]          awaddr_q;
  logic                aw_have_q;
  logic [7:0]          wdata_q;
  logic                wlane_q;
  logic                w_have_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                rd_latched_q;
  logic                rd_first_hi_q;
  logic [15:0]         rd_buf_q;
  logic [15:0]         wr_buf_q;
  logic                wr_got_hi_q;
  logic                wr_got_lo_q;
  logic                wr_pend_q;
  logic                pin_q;
  logic                pin_prev_q;
  tcmv_pkg::tcmv_mode_t mode;
  logic [1:0]          els;
  logic [1:0]          clks;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_ctrl;
  logic                wr_cfg;
  logic                wr_hi;
  logic                wr_lo;
  logic                wr_val;
  logic                rd_hi;
  logic                rd_lo;
  logic                buf_wr;
  logic                dbg_wr;
  logic [15:0]         wr_buf_d;
  logic                wr_both_d;
  logic                imm_load;
  logic                pend_load;
  logic [15:0]         pwm_top;
  logic                rise;
  logic                fall;
  logic                match_hit;
  logic [7:0]          rd_byte;
  logic                rd_ok;

  // ctrl_q keeps the control bits from edge_level_lo upward
  localparam int unsigned CTRL_BASE = tcmv_pkg::CTRL_ELS_LO;
  localparam int unsigned ELS_HI_B  = tcmv_pkg::CTRL_ELS_HI - CTRL_BASE;
  localparam int unsigned MS_LO_B   = tcmv_pkg::CTRL_MS_LO - CTRL_BASE;
  localparam int unsigned MS_HI_B   = tcmv_pkg::CTRL_MS_HI - CTRL_BASE;

  assign els  = ctrl_q[ELS_HI_B:0];
  assign clks = cfg_q[tcmv_pkg::CFG_CLKS_HI:tcmv_pkg::CFG_CLKS_LO];

  // mode decode
  always_comb begin
    if (cfg_q[tcmv_pkg::CFG_CENTER_ALIGN_SELECT]) begin
      mode = tcmv_pkg::MODE_CENTER_ALIGNED_PWM;
    end else if (ctrl_q[MS_HI_B]) begin
      mode = tcmv_pkg::MODE_EDGE_ALIGNED_PWM;
    end else if (ctrl_q[MS_LO_B]) begin
      mode = tcmv_pkg::MODE_COMPARE;
    end else begin
      mode = tcmv_pkg::MODE_CAPTURE;
    end
  end

  // pin ownership: only the output modes drive, only non-zero els owns
  assign pin_timer_owned = (els != tcmv_pkg::ELS_OFF);
  assign pin_oe = pin_timer_owned && (mode != tcmv_pkg::MODE_CAPTURE);
  assign pin_out = pin_q;

  // bus handshakes
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  // narrow registers only take the low byte lane
  assign wr_ctrl = wr_fire && wlane_q && awaddr_q == tcmv_pkg::ADDR_CTRL;
  assign wr_cfg  = wr_fire && wlane_q && awaddr_q == tcmv_pkg::ADDR_CFG;
  assign wr_hi   = wr_fire && wlane_q && awaddr_q == tcmv_pkg::ADDR_VAL_HI;
  assign wr_lo   = wr_fire && wlane_q && awaddr_q == tcmv_pkg::ADDR_VAL_LO;
  assign wr_val  = (wr_hi || wr_lo) && mode != tcmv_pkg::MODE_CAPTURE;
  assign buf_wr  = wr_val && !background_debug_mode;
  assign dbg_wr  = wr_val && background_debug_mode;
  assign rd_hi   = rd_fire && s_axi_araddr == tcmv_pkg::ADDR_VAL_HI;
  assign rd_lo   = rd_fire && s_axi_araddr == tcmv_pkg::ADDR_VAL_LO;

  // write buffer view including the byte arriving this cycle
  always_comb begin
    wr_buf_d = wr_buf_q;
    if (buf_wr && wr_hi) begin
      wr_buf_d[15:8] = wdata_q;
    end
    if (buf_wr && wr_lo) begin
      wr_buf_d[7:0] = wdata_q;
    end
    wr_both_d = (wr_got_hi_q || wr_hi) && (wr_got_lo_q || wr_lo);
  end

  assign imm_load = buf_wr && wr_both_d && clks == tcmv_pkg::CLKS_NONE;
  // a modulo of zero means the counter runs free to its top
  assign pwm_top = (modulo_value == tcmv_pkg::MOD_FREE) ?
                   tcmv_pkg::FREE_TOP : modulo_value;
  always_comb begin
    pend_load = 1'b0;
    if (wr_pend_q && count_advance) begin
      if (mode == tcmv_pkg::MODE_COMPARE) begin
        pend_load = 1'b1;
      end else if (mode != tcmv_pkg::MODE_CAPTURE) begin
        pend_load = (counter_value == pwm_top);
      end
    end
  end

  // pin edges; pin is synchronous, the caller owns settle time
  assign rise = pin_in && !pin_prev_q;
  assign fall = !pin_in && pin_prev_q;
  always_comb begin
    capture_event = 1'b0;
    if (mode == tcmv_pkg::MODE_CAPTURE) begin
      unique case (els)
        tcmv_pkg::ELS_RISE: capture_event = rise;
        tcmv_pkg::ELS_FALL: capture_event = fall;
        tcmv_pkg::ELS_BOTH: capture_event = rise || fall;
        tcmv_pkg::ELS_OFF:  capture_event = 1'b0;
      endcase
    end
  end

  assign match_hit = count_advance && counter_value == value_q;
  assign compare_match = match_hit && mode != tcmv_pkg::MODE_CAPTURE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  // waveform
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      unique case (mode)
        tcmv_pkg::MODE_CAPTURE: pin_q <= 1'b0;
        tcmv_pkg::MODE_COMPARE: begin
          if (match_hit) begin
            unique case (els)
              tcmv_pkg::ELS_RISE: pin_q <= !pin_q;
              tcmv_pkg::ELS_FALL: pin_q <= 1'b0;
              tcmv_pkg::ELS_BOTH: pin_q <= 1'b1;
              tcmv_pkg::ELS_OFF:  pin_q <= pin_q;
            endcase
          end
        end
        tcmv_pkg::MODE_EDGE_ALIGNED_PWM: begin
          // period starts at the wrap to zero, match ends the pulse
          if (match_hit) begin
            pin_q <= els[0];
          end else if (count_advance &&
                       counter_value == tcmv_pkg::COUNT_ZERO) begin
            pin_q <= !els[0];
          end
        end
        tcmv_pkg::MODE_CENTER_ALIGNED_PWM: begin
          if (match_hit) begin
            pin_q <= count_up ? els[0] : !els[0];
          end
        end
      endcase
    end
  end

  // control and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= tcmv_pkg::CTRL_RESET;
      cfg_q  <= tcmv_pkg::CFG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[tcmv_pkg::CTRL_MS_HI:tcmv_pkg::CTRL_ELS_LO];
      end
      if (wr_cfg) begin
        cfg_q <= wdata_q[tcmv_pkg::CFG_CLKS_HI:tcmv_pkg::CFG_CENTER_ALIGN_SELECT];
      end
    end
  end

  // channel value: capture beats any bus load in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= tcmv_pkg::VALUE_RESET;
    end else if (capture_event) begin
      value_q <= counter_value;
    end else if (dbg_wr && wr_hi) begin
      value_q[15:8] <= wdata_q;
    end else if (dbg_wr) begin
      value_q[7:0] <= wdata_q;
    end else if (imm_load) begin
      value_q <= wr_buf_d;
    end else if (pend_load) begin
      value_q <= wr_buf_q;
    end
  end

  // write coherency; debug writes never touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_buf_q    <= tcmv_pkg::VALUE_RESET;
      wr_got_hi_q <= 1'b0;
      wr_got_lo_q <= 1'b0;
      wr_pend_q   <= 1'b0;
    end else if (wr_ctrl) begin
      wr_got_hi_q <= 1'b0;
      wr_got_lo_q <= 1'b0;
      wr_pend_q   <= 1'b0;
    end else if (buf_wr) begin
      wr_buf_q <= wr_buf_d;
      if (wr_both_d) begin
        wr_got_hi_q <= 1'b0;
        wr_got_lo_q <= 1'b0;
        wr_pend_q   <= (clks != tcmv_pkg::CLKS_NONE);
      end else begin
        wr_got_hi_q <= wr_got_hi_q || wr_hi;
        wr_got_lo_q <= wr_got_lo_q || wr_lo;
        // a load taken this cycle must not be applied again later
        wr_pend_q   <= wr_pend_q && !pend_load;
      end
    end else if (pend_load) begin
      wr_pend_q <= 1'b0;
    end
  end

  // read coherency, only in capture mode and frozen in debug except for control writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_latched_q  <= 1'b0;
      rd_first_hi_q <= 1'b0;
      rd_buf_q      <= tcmv_pkg::VALUE_RESET;
    end else if (wr_ctrl) begin
      rd_latched_q <= 1'b0;
    end else if (!background_debug_mode &&
                 mode == tcmv_pkg::MODE_CAPTURE) begin
      if (!rd_latched_q && (rd_hi || rd_lo)) begin
        rd_latched_q  <= 1'b1;
        rd_first_hi_q <= rd_hi;
        rd_buf_q      <= value_q;
      end else if (rd_latched_q && (rd_first_hi_q ? rd_lo : rd_hi)) begin
        rd_latched_q <= 1'b0;
      end
    end
  end

  // read data select
  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      tcmv_pkg::ADDR_CTRL:   rd_byte = {2'h0, ctrl_q, 2'h0};
      tcmv_pkg::ADDR_CFG:    rd_byte = {5'h00, cfg_q};
      tcmv_pkg::ADDR_VAL_HI: begin
        if (rd_latched_q && !background_debug_mode) begin
          rd_byte = rd_buf_q[15:8];
        end else begin
          rd_byte = value_q[15:8];
        end
      end
      tcmv_pkg::ADDR_VAL_LO: begin
        if (rd_latched_q && !background_debug_mode) begin
          rd_byte = rd_buf_q[7:0];
        end else begin
          rd_byte = value_q[7:0];
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // bus write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= tcmv_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q == tcmv_pkg::ADDR_CTRL ||
                      awaddr_q == tcmv_pkg::ADDR_CFG ||
                      awaddr_q == tcmv_pkg::ADDR_VAL_HI ||
                      awaddr_q == tcmv_pkg::ADDR_VAL_LO) ?
                     tcmv_pkg::RESP_OKAY : tcmv_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // bus read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= tcmv_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_ok ? tcmv_pkg::RESP_OKAY : tcmv_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  property p_edge_aligned_pwm_sel;
    @(posedge aclk) disable iff (!aresetn)
    !cfg_q[0] && ctrl_q[3] |-> mode == tcmv_pkg::MODE_EDGE_ALIGNED_PWM;
  endproperty
  a_edge_aligned_pwm_sel: assert property (p_edge_aligned_pwm_sel) else $error("edge_aligned_pwm not selected");

  property p_cap_cmp_sel;
    @(posedge aclk) disable iff (!aresetn)
    !cfg_q[0] && !ctrl_q[3] |->
      mode == (ctrl_q[2] ? tcmv_pkg::MODE_COMPARE : tcmv_pkg::MODE_CAPTURE);
  endproperty
  a_cap_cmp_sel: assert property (p_cap_cmp_sel) else $error("bad mode");

  property p_gpio;
    @(posedge aclk) disable iff (!aresetn)
    els == 2'h0 |-> !pin_oe && !pin_timer_owned && !capture_event;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not released");

  property p_rise_cap;
    @(posedge aclk) disable iff (!aresetn)
    mode == tcmv_pkg::MODE_CAPTURE && els == 2'h1 && pin_in && !pin_prev_q
      |=> value_q == $past(counter_value);
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("no capture");

  property p_toggle;
    @(posedge aclk) disable iff (!aresetn)
    mode == tcmv_pkg::MODE_COMPARE && els == 2'h1 && match_hit
      |=> pin_out != $past(pin_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_edge_aligned_pwm_clr;
    @(posedge aclk) disable iff (!aresetn)
    mode == tcmv_pkg::MODE_EDGE_ALIGNED_PWM && els == 2'h2 && match_hit |=> !pin_out;
  endproperty
  a_edge_aligned_pwm_clr: assert property (p_edge_aligned_pwm_clr) else $error("edge_aligned_pwm not low");

  property p_center_aligned_pwm_up;
    @(posedge aclk) disable iff (!aresetn)
    mode == tcmv_pkg::MODE_CENTER_ALIGNED_PWM && match_hit && count_up
      |=> pin_out == $past(els[0]);
  endproperty
  a_center_aligned_pwm_up: assert property (p_center_aligned_pwm_up) else $error("center_aligned_pwm level");

  property p_reset_val;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> value_q == 16'h0000 && !pin_out;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("value not 0");

  property p_ctrl_clr;
    @(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> !rd_latched_q && !wr_got_hi_q && !wr_got_lo_q;
  endproperty
  a_ctrl_clr: assert property (p_ctrl_clr) else $error("latch kept");

  property p_cap_nowr;
    @(posedge aclk) disable iff (!aresetn)
    (wr_hi || wr_lo) && mode == tcmv_pkg::MODE_CAPTURE && !capture_event
      |=> $stable(value_q);
  endproperty
  a_cap_nowr: assert property (p_cap_nowr) else $error("cap write");

  property p_imm;
    @(posedge aclk) disable iff (!aresetn)
    wr_lo && !background_debug_mode && mode == tcmv_pkg::MODE_COMPARE &&
      wr_got_hi_q && clks == 2'h0 && !capture_event
      |=> value_q == {$past(wr_buf_q[15:8]), $past(wdata_q)};
  endproperty
  a_imm: assert property (p_imm) else $error("no immediate load");

endmodule : tcmv_channel

`default_nettype wire
